// File: adc_cfg_pkg.sv
package adc_cfg_pkg;

    localparam logic [7:0]  ADDR_RESET      = 8'h00;
    localparam logic [7:0]  ADDR_LVDS_DRIVE = 8'h11;
    localparam logic [7:0]  ADDR_NOISE_SUP  = 8'h14;
    localparam logic [7:0]  ADDR_SWAP_POL   = 8'h24;
    localparam logic [7:0]  ADDR_GAIN_LO    = 8'h2A;
    localparam logic [7:0]  ADDR_GAIN_HI    = 8'h2B;
    localparam logic [7:0]  ADDR_CLOCKING   = 8'h42;
    localparam logic [7:0]  ADDR_OUT_FORMAT = 8'h46;

    localparam int          RESET_BIT       = 0;
    localparam int          DIFF_CLK_BIT    = 0;
    localparam int          DCC_BIT         = 2;
    localparam int          EXT_VCM_BIT     = 3;
    localparam int          PHASE_LSB       = 5;
    localparam int          BTC_BIT         = 2;
    localparam int          MSB_FIRST_BIT   = 3;
    localparam int          SDR_BIT         = 4;
    localparam int          SWAP_POL_BIT    = 0;
    localparam int          BIT_CLOCK_OUTPUT_DRV_LSB    = 0;
    localparam int          FRAME_DRV_LSB   = 4;
    localparam int          DATA_DRV_LSB    = 8;

    localparam logic [15:0] RESET_VALUE     = 16'h0000;
    localparam logic [1:0]  PHASE_DEFAULT   = 2'h0;
    localparam logic [2:0]  DRIVE_3MA5      = 3'h0;
    localparam logic [3:0]  GAIN_0DB        = 4'h0;
    localparam logic [3:0]  GAIN_MAX        = 4'hC;
    localparam int          RESET_CYCLES    = 2;

endpackage : adc_cfg_pkg

// File: adc_config_register_bank.sv
// Operation
// - Writing one at address zero restores defaults.
// - Offset binary default; two's complement via 46.
// - LSB first default; MSB first via 46.
// - DDR default; SDR selectable via 46.
// - Gain 0 to 12 dB in 2A, 2B.
// - Input polarity swap off; enabled via 24.
// - Bit clock phase selectable via 42.
// - Single-ended clock default; differential via 42.
// - Duty-cycle correction off; enabled via 42.
// - Common-mode reference drive off; via 42.
// - Noise suppression via 14 toggles at half rate.
// - LVDS drive 3.5 mA default; via 11.
module adc_config_register_bank
    import adc_cfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [7:0]  rd_addr,
    output logic      [15:0] rd_data,
    input  wire logic        sample_strobe,
    output logic             twos_complement_format,
    output logic             msb_first,
    output logic             sdr_mode,
    output logic [1:0]       bit_clock_output_phase,
    output logic             differential_clock,
    output logic             duty_cycle_correction,
    output logic             ext_ref_vcm,
    output logic             swap_input_polarity,
    output logic [7:0]       noise_suppress_en,
    output logic [7:0]       noise_flip,
    output logic [31:0]      channel_gain,
    output logic [2:0]       bit_clock_output_drive,
    output logic [2:0]       frame_drive,
    output logic [2:0]       data_drive,
    output logic             reset_busy
);

    logic        rst_meta;
    logic        rst_n;
    logic [15:0] reg_drive;
    logic [15:0] reg_noise;
    logic [15:0] reg_swap;
    logic [15:0] reg_gain_lo;
    logic [15:0] reg_gain_hi;
    logic [15:0] reg_clocking;
    logic [15:0] reg_format;
    logic [1:0]  reset_count;
    logic        soft_reset;
    logic        clear_all;

    // Gain codes above 12 dB are clamped so the datapath never sees them.
    function automatic logic [3:0] clamp_gain(input logic [3:0] code);
        clamp_gain = (code > GAIN_MAX) ? GAIN_MAX : code;
    endfunction : clamp_gain

    // One write decode shared by the reset strobe and every register.
    function automatic logic write_hit(input logic       en,
                                       input logic [7:0] addr,
                                       input logic [7:0] target);
        write_hit = en && (addr == target);
    endfunction : write_hit

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    assign soft_reset = write_hit(wr_en, wr_addr, ADDR_RESET) && wr_data[RESET_BIT];

    // Reset bit is not stored; a short busy count stands for the pulse, then clears.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_count <= 2'h0;
        end else if (soft_reset) begin
            reset_count <= 2'(RESET_CYCLES);
        end else if (reset_count != 2'h0) begin
            reset_count <= reset_count - 2'h1;
        end
    end

    assign reset_busy = reset_count != 2'h0;

    // The strobe cycle and the busy tail both refuse writes, so nothing escapes the clear.
    assign clear_all = soft_reset || reset_busy;

    // Whole-word writes: every field of a register changes together.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_drive <= RESET_VALUE;
        end else if (clear_all) begin
            reg_drive <= RESET_VALUE;
        end else if (write_hit(wr_en, wr_addr, ADDR_LVDS_DRIVE)) begin
            reg_drive <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_noise <= RESET_VALUE;
        end else if (clear_all) begin
            reg_noise <= RESET_VALUE;
        end else if (write_hit(wr_en, wr_addr, ADDR_NOISE_SUP)) begin
            reg_noise <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_swap <= RESET_VALUE;
        end else if (clear_all) begin
            reg_swap <= RESET_VALUE;
        end else if (write_hit(wr_en, wr_addr, ADDR_SWAP_POL)) begin
            reg_swap <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_gain_lo <= RESET_VALUE;
        end else if (clear_all) begin
            reg_gain_lo <= RESET_VALUE;
        end else if (write_hit(wr_en, wr_addr, ADDR_GAIN_LO)) begin
            reg_gain_lo <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_gain_hi <= RESET_VALUE;
        end else if (clear_all) begin
            reg_gain_hi <= RESET_VALUE;
        end else if (write_hit(wr_en, wr_addr, ADDR_GAIN_HI)) begin
            reg_gain_hi <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_clocking <= RESET_VALUE;
        end else if (clear_all) begin
            reg_clocking <= RESET_VALUE;
        end else if (write_hit(wr_en, wr_addr, ADDR_CLOCKING)) begin
            reg_clocking <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_format <= RESET_VALUE;
        end else if (clear_all) begin
            reg_format <= RESET_VALUE;
        end else if (write_hit(wr_en, wr_addr, ADDR_OUT_FORMAT)) begin
            reg_format <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
        end else begin
            case (rd_addr)
                ADDR_RESET:      rd_data <= 16'h0000;
                ADDR_LVDS_DRIVE: rd_data <= reg_drive;
                ADDR_NOISE_SUP:  rd_data <= reg_noise;
                ADDR_SWAP_POL:   rd_data <= reg_swap;
                ADDR_GAIN_LO:    rd_data <= reg_gain_lo;
                ADDR_GAIN_HI:    rd_data <= reg_gain_hi;
                ADDR_CLOCKING:   rd_data <= reg_clocking;
                ADDR_OUT_FORMAT: rd_data <= reg_format;
                default:         rd_data <= 16'h0000;
            endcase
        end
    end

    assign twos_complement_format = reg_format[BTC_BIT];
    assign msb_first              = reg_format[MSB_FIRST_BIT];
    assign sdr_mode               = reg_format[SDR_BIT];
    assign bit_clock_output_phase = reg_clocking[PHASE_LSB +: 2];
    assign differential_clock     = reg_clocking[DIFF_CLK_BIT];
    assign duty_cycle_correction  = reg_clocking[DCC_BIT];
    assign ext_ref_vcm            = reg_clocking[EXT_VCM_BIT];
    assign swap_input_polarity    = reg_swap[SWAP_POL_BIT];
    assign noise_suppress_en      = reg_noise[7:0];
    assign bit_clock_output_drive             = reg_drive[BIT_CLOCK_OUTPUT_DRV_LSB +: 3];
    assign frame_drive            = reg_drive[FRAME_DRV_LSB +: 3];
    assign data_drive             = reg_drive[DATA_DRV_LSB +: 3];

    always_comb begin
        channel_gain = {32{1'b0}};
        for (int i = 0; i < 4; i++) begin
            channel_gain[i*4 +: 4]      = clamp_gain(reg_gain_lo[i*4 +: 4]);
            channel_gain[16 + i*4 +: 4] = clamp_gain(reg_gain_hi[12 - i*4 +: 4]);
        end
    end

    for (genvar ch = 0; ch < 8; ch++) begin : g_noise
        noise_toggle u_toggle (
            .clk           (clk),
            .rst_n         (rst_n),
            .enable        (noise_suppress_en[ch]),
            .sample_strobe (sample_strobe),
            .flip          (noise_flip[ch])
        );
    end

    soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        soft_reset |=> ##1 reg_format == RESET_VALUE && reg_clocking == RESET_VALUE)
        else $error("soft reset did not restore defaults");

    reset_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
        soft_reset ##1 !soft_reset [*2] |=> !reset_busy)
        else $error("reset bit did not self clear");

    busy_span_a: assert property (@(posedge clk) disable iff (!rst_n)
        soft_reset |=> reset_busy ##1 reset_busy)
        else $error("reset busy too short");

    busy_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        reset_busy |=> reg_format == RESET_VALUE && reg_swap == RESET_VALUE
            && reg_drive == RESET_VALUE && reg_gain_lo == RESET_VALUE)
        else $error("write landed during soft reset");

    reset_reads_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_addr == ADDR_RESET |=> rd_data == 16'h0000)
        else $error("reset register read nonzero");

    format_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_addr == ADDR_OUT_FORMAT |=> rd_data == $past(reg_format))
        else $error("format register read back wrong");

    format_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && wr_addr == ADDR_OUT_FORMAT && !reset_busy
        |=> twos_complement_format == $past(wr_data[BTC_BIT])
            && msb_first == $past(wr_data[MSB_FIRST_BIT])
            && sdr_mode == $past(wr_data[SDR_BIT]))
        else $error("format fields not updated");

    gain_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
        channel_gain[3:0] <= GAIN_MAX && channel_gain[31:28] <= GAIN_MAX)
        else $error("gain above 12 dB");

    gain_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && wr_addr == ADDR_GAIN_LO && !reset_busy
        |=> reg_gain_lo == $past(wr_data))
        else $error("low gain register not updated");

    gain_hi_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && wr_addr == ADDR_GAIN_HI && !reset_busy
        |=> reg_gain_hi == $past(wr_data))
        else $error("high gain register not updated");

    for (genvar g = 0; g < 8; g++) begin : g_gain_limit
        gain_each_a: assert property (@(posedge clk) disable iff (!rst_n)
            channel_gain[g*4 +: 4] <= GAIN_MAX)
            else $error("channel gain above limit");
    end

    clock_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && wr_addr == ADDR_CLOCKING && !reset_busy
        |=> differential_clock == $past(wr_data[DIFF_CLK_BIT])
            && duty_cycle_correction == $past(wr_data[DCC_BIT])
            && ext_ref_vcm == $past(wr_data[EXT_VCM_BIT])
            && bit_clock_output_phase == $past(wr_data[PHASE_LSB +: 2]))
        else $error("clocking fields not updated");

    swap_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && wr_addr == ADDR_SWAP_POL && !reset_busy
        |=> swap_input_polarity == $past(wr_data[SWAP_POL_BIT]))
        else $error("polarity swap not updated");

    noise_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && wr_addr == ADDR_NOISE_SUP && !reset_busy
        |=> noise_suppress_en == $past(wr_data[7:0]))
        else $error("noise enables not updated");

    noise_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        noise_suppress_en == 8'h00 |=> noise_flip == 8'h00)
        else $error("noise toggle active while disabled");

    drive_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && wr_addr == ADDR_LVDS_DRIVE && !reset_busy
        |=> bit_clock_output_drive == $past(wr_data[BIT_CLOCK_OUTPUT_DRV_LSB +: 3])
            && frame_drive == $past(wr_data[FRAME_DRV_LSB +: 3])
            && data_drive == $past(wr_data[DATA_DRV_LSB +: 3]))
        else $error("drive fields not updated");

    drive_default_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(reset_busy) && !reset_busy |-> bit_clock_output_drive == DRIVE_3MA5
            && frame_drive == DRIVE_3MA5
            && data_drive == DRIVE_3MA5)
        else $error("drive current not at default");

    defaults_restored_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(reset_busy) && !reset_busy |-> channel_gain == 32'h0
            && !swap_input_polarity && noise_suppress_en == 8'h00
            && !twos_complement_format && !differential_clock)
        else $error("soft reset left a field set");

    reset_seen_c:  cover property (@(posedge clk) disable iff (!rst_n) soft_reset);
    busy_tail_c:   cover property (@(posedge clk) disable iff (!rst_n) soft_reset ##3 !reset_busy);
    format_set_c:  cover property (@(posedge clk) disable iff (!rst_n) sdr_mode && msb_first);
    noise_on_c:    cover property (@(posedge clk) disable iff (!rst_n) noise_flip[0]);
    gain_clamp_c:  cover property (@(posedge clk) disable iff (!rst_n)
        reg_gain_lo[3:0] > GAIN_MAX);

endmodule : adc_config_register_bank

// File: host_model.sv
module host_model
    import adc_cfg_pkg::*;
(
    input  wire logic        clk,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [15:0]      wr_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wr_en   = 1'b0;
        wr_addr = 8'hFF;
        wr_data = 16'hFFFF;
    end

    function automatic logic [15:0] defined_bits(input logic [7:0] a);
        case (a)
            ADDR_RESET:      return 16'h0001;
            ADDR_LVDS_DRIVE: return 16'h0777;
            ADDR_NOISE_SUP:  return 16'h00FF;
            ADDR_SWAP_POL:   return 16'h0001;
            ADDR_CLOCKING:   return 16'h006D;
            ADDR_OUT_FORMAT: return 16'h001C;
            default:         return 16'hFFFF;
        endcase
    endfunction : defined_bits

    // Address and data are scrambled once released, so stale values never look valid.
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en   <= 1'b1;
        wr_addr <= a;
        wr_data <= d & defined_bits(a);
        @(posedge clk);
        wr_en   <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask : write_reg
endmodule : host_model

// File: noise_toggle.sv
module noise_toggle
    import adc_cfg_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic sample_strobe,
    output logic      flip
);

    // Alternates each sample, so a zero input toggles the codes at half rate.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flip <= 1'b0;
        end else if (!enable) begin
            flip <= 1'b0;
        end else if (sample_strobe) begin
            flip <= ~flip;
        end
    end

    toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
        enable && $past(enable) && sample_strobe |=> flip != $past(flip))
        else $error("noise suppression did not toggle");

endmodule : noise_toggle

// File: tb_adc_config_register_bank.sv
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin bad_count++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb_adc_config_register_bank;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_cfg_pkg::*;
    logic clk, arst_n, wr_en, sample_strobe;
    logic tc, mf, sdr, dclk, dcc, vcm, swp, busy, f0;
    logic [1:0]  phase;
    logic [7:0]  wr_addr, rd_addr, ns_en, ns_flip;
    logic [15:0] wr_data, rd_data;
    logic [31:0] gain;
    logic [2:0]  bit_clock_output_drv, frame_drv, data_drv;
    int          bad_count = 0;
    int          n_checks = 0;

    adc_config_register_bank i_dut (.clk(clk), .arst_n(arst_n), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
        .sample_strobe(sample_strobe), .twos_complement_format(tc), .msb_first(mf),
        .sdr_mode(sdr), .bit_clock_output_phase(phase), .differential_clock(dclk),
        .duty_cycle_correction(dcc), .ext_ref_vcm(vcm), .swap_input_polarity(swp),
        .noise_suppress_en(ns_en), .noise_flip(ns_flip), .channel_gain(gain),
        .bit_clock_output_drive(bit_clock_output_drv), .frame_drive(frame_drv), .data_drive(data_drv),
        .reset_busy(busy));
    host_model i_host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic close_out;
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    task automatic wr_wait(input logic [7:0] a, input logic [15:0] d);
        i_host.write_reg(a, d);
        @(posedge clk);
        #1;
    endtask : wr_wait

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] ex, input string nm);
        @(posedge clk);
        rd_addr <= a;
        @(posedge clk);
        #1;
        `CHK(nm, ex, rd_data)
    endtask : rd_chk

    task automatic test_defaults;
        `CHK("fmt", 3'h0, {tc, mf, sdr})
        `CHK("clkcfg", 5'h00, {phase, dclk, dcc, vcm})
        `CHK("gain", 32'h0, gain)
        `CHK("swap", 1'b0, swp)
        `CHK("noise", 16'h0, {ns_en, ns_flip})
        `CHK("drive", 9'h000, {bit_clock_output_drv, frame_drv, data_drv})
    endtask : test_defaults

    task automatic test_format;
        for (int b = 2; b <= 4; b++) begin
            wr_wait(ADDR_OUT_FORMAT, 16'h0001 << b);
            `CHK("fmt", 3'b100 >> (b - 2), {tc, mf, sdr})
            rd_chk(ADDR_OUT_FORMAT, 16'h0001 << b, "fmt rd");
        end
    endtask : test_format

    task automatic test_clocking;
        wr_wait(ADDR_CLOCKING, 16'h006D);
        `CHK("clkcfg", 5'h1F, {phase, dclk, dcc, vcm})
        wr_wait(ADDR_CLOCKING, 16'h0020);
        `CHK("phase", 5'h08, {phase, dclk, dcc, vcm})
    endtask : test_clocking

    task automatic test_gain;
        wr_wait(ADDR_GAIN_LO, 16'h4321);
        wr_wait(ADDR_GAIN_HI, 16'h5678);
        `CHK("gain", 32'h87654321, gain)
        wr_wait(ADDR_GAIN_LO, 16'h000F);
        `CHK("gain max", 16'h000C, gain[15:0])
    endtask : test_gain

    task automatic test_misc;
        wr_wait(ADDR_SWAP_POL, 16'h0001);
        `CHK("swap", 1'b1, swp)
        wr_wait(ADDR_LVDS_DRIVE, 16'h0765);
        `CHK("drive", 9'h177, {bit_clock_output_drv, frame_drv, data_drv})
        rd_chk(8'h50, 16'h0000, "unmapped");
        wr_wait(ADDR_NOISE_SUP, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            f0 = ns_flip[0];
            sample_strobe <= 1'b1;
            @(posedge clk);
            sample_strobe <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
            `CHK("flip", ~f0, ns_flip[0])
            `CHK("flip off", 7'h00, ns_flip[7:1])
        end
    endtask : test_misc

    task automatic test_reset;
        wr_wait(ADDR_RESET, 16'h0000);
        `CHK("no reset", 1'b1, swp)
        i_host.write_reg(ADDR_RESET, 16'h0001);
        @(posedge clk);
        #1;
        `CHK("busy", 1'b1, busy)
        `CHK("cleared", 44'h0, {swp, gain, bit_clock_output_drv, frame_drv, data_drv, tc, mf})
        repeat (2) @(posedge clk);
        #1;
        `CHK("busy end", 1'b0, busy)
        rd_chk(ADDR_RESET, 16'h0000, "rst rd");
        rd_chk(ADDR_GAIN_HI, 16'h0000, "gain rd");
    endtask : test_reset

    task automatic test_refused;
        wr_wait(ADDR_SWAP_POL, 16'h0001);
        `CHK("swap again", 1'b1, swp)
        i_host.write_reg(ADDR_RESET, 16'h0001);
        i_host.write_reg(ADDR_SWAP_POL, 16'h0001);
        @(posedge clk);
        #1;
        `CHK("dropped", 1'b0, swp)
        wr_wait(ADDR_RESET, 16'h0000);
        `CHK("no rearm", 1'b0, busy)
        rd_chk(ADDR_RESET, 16'h0000, "rst rd again");
    endtask : test_refused

    initial begin
        #100000;
        bad_count++;
        close_out();
    end

    initial begin
        arst_n = 1'b0;
        rd_addr = 8'h00;
        sample_strobe = 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        test_defaults();
        test_format();
        test_clocking();
        test_gain();
        test_misc();
        test_reset();
        test_refused();
        close_out();
    end
endmodule : tb_adc_config_register_bank
